// [hw/gdp_defs.vh]
// constants for the general purpose pin data bank: register indices,
// configuration field positions, reset values and the map of real pins.
// assumes it is included by the bank's design files and the bench top only.
`ifndef GDP_DEFS_VH
`define GDP_DEFS_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define GDP_IDX_W 7
`define GDP_IDX_GROUP_ONE 7'h4b
`define GDP_IDX_GROUP_TWO 7'h4c
`define GDP_IDX_GROUP_THREE 7'h4d
`define GDP_IDX_GROUP_FOUR 7'h4e
`define GDP_IDX_GROUP_FIVE 7'h4f
`define GDP_IDX_GROUP_SIX 7'h50
`define GDP_IDX_CFG_BASE 7'h00
`define GDP_NUM_GROUPS 6
`define GDP_NUM_PORTS 48

// ****************************************************************
// configuration register fields
// ****************************************************************
`define GDP_CFG_DIR 0
`define GDP_CFG_POL 1
`define GDP_CFG_FSEL_LO 2
`define GDP_CFG_FSEL_HI 3
`define GDP_CFG_OD 7
`define GDP_CFG_RESET 8'h01
`define GDP_DATA_RESET 1'b0
`define GDP_FSEL_GPIO 2'h0

// ****************************************************************
// port positions that carry a pin (group four bits 4..7 and group six
// bits 3..7 are reserved)
// ****************************************************************
`define GDP_PIN_MASK 48'h07_ff_0f_ff_ff_ff

`endif

// [hw/gdp_sync2.v]
// two flip-flop synchroniser for a vector of asynchronous pin levels.
// assumes the inputs come straight from pads, outside clk_sys.
`timescale 1ns/1ps
module gdp_sync2 #(
  parameter WIDTH = 48
) (
  input wire clk_sys,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // first stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (rst) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// [hw/gdp_pin_cell.v]
// one general purpose port: its configuration byte, its data bit and
// the pin driver with polarity and open-drain control.
// assumes pin_lvl is already synchronised to clk_sys.
`timescale 1ns/1ps
`include "gdp_defs.vh"
module gdp_pin_cell (
  input wire clk_sys,
  input wire rst,
  input wire cfg_we,
  input wire [7:0] cfg_wdat,
  input wire data_we,
  input wire data_wbit,
  input wire data_rd,
  input wire pin_lvl,
  input wire alt_out,
  input wire alt_dir_in,
  output reg [7:0] cfg,
  output wire rd_view,
  output reg pin_o,
  output reg pin_oe_n,
  output wire alt_in
);

  wire dir_in;
  wire pol;
  wire od;
  wire gpio_fn;
  reg data;
  reg drv_en;
  reg drv_val;

  assign dir_in = cfg[`GDP_CFG_DIR];
  assign pol = cfg[`GDP_CFG_POL];
  assign od = cfg[`GDP_CFG_OD];
  assign gpio_fn = (cfg[`GDP_CFG_FSEL_HI:`GDP_CFG_FSEL_LO] == `GDP_FSEL_GPIO);

  // configuration byte, plain input function after reset
  always @(posedge clk_sys) begin
    if (rst) begin
      cfg <= `GDP_CFG_RESET;
    end else if (cfg_we) begin
      cfg <= cfg_wdat;
    end
  end

  // data bit: written only as output, latched from pin on input read
  always @(posedge clk_sys) begin
    if (rst) begin
      data <= `GDP_DATA_RESET;
    end else if (data_we && !dir_in) begin
      data <= data_wbit;
    end else if (data_rd && dir_in) begin
      data <= pin_lvl ^ pol;
    end
  end

  // value a host read returns: pin for inputs, the data bit for outputs
  assign rd_view = dir_in ? (pin_lvl ^ pol) : data;

  // level seen by an alternate function, polarity applied
  assign alt_in = pin_lvl ^ pol;

  // source of the drive: data bit or the selected alternate function
  always @* begin
    if (gpio_fn) begin
      drv_en = !dir_in;
      drv_val = data ^ pol;
    end else begin
      drv_en = !alt_dir_in;
      drv_val = alt_out ^ pol;
    end
  end

  // registered driver; open-drain only pulls low
  always @(posedge clk_sys) begin
    if (rst) begin
      pin_o <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_o <= od ? 1'b0 : drv_val;
      pin_oe_n <= !(drv_en && !(od && drv_val));
    end
  end

endmodule

// [hw/gdp_gpio_bank.v]
// bank of general purpose ports behind a classic wishbone slave.
// assumes a wishbone master on clk_sys and raw pad signals on the pins;
// the pad wire level is resolved outside from pin_o and pin_oe_n.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "gdp_defs.vh"
module gdp_gpio_bank #(
  parameter ADDR_W = 9,
  parameter NUM_PORTS = `GDP_NUM_PORTS,
  parameter [47:0] PIN_MASK = `GDP_PIN_MASK
) (
  input wire clk_sys,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [NUM_PORTS-1:0] pin_i,
  output wire [NUM_PORTS-1:0] pin_o,
  output wire [NUM_PORTS-1:0] pin_oe_n,
  input wire [NUM_PORTS-1:0] alt_out,
  input wire [NUM_PORTS-1:0] alt_dir_in,
  output wire [NUM_PORTS-1:0] alt_in,
  output wire [2*NUM_PORTS-1:0] fn_sel
);

  // ****************************************************************
  // bus request decode
  // ****************************************************************

  wire req;
  wire wr_req;
  wire rd_req;
  wire lane0;
  wire [`GDP_IDX_W-1:0] idx;
  wire [`GDP_IDX_W-1:0] grp_full;
  wire [2:0] grp;
  wire is_data;
  wire is_cfg_range;
  wire [`GDP_IDX_W-1:0] cfg_full;
  wire [5:0] cfg_port;
  wire is_cfg;

  // new request only while no answer is pending
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // a write commits at the edge where the master sees ack high
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd_req = req && !wb_we_i;
  assign lane0 = wb_sel_i[0];

  // word index from the byte address
  assign idx = wb_adr_i[`GDP_IDX_W+1:2];

  // group registers occupy six consecutive indices
  assign grp_full = idx - `GDP_IDX_GROUP_ONE;
  assign grp = grp_full[2:0];
  assign is_data = (idx >= `GDP_IDX_GROUP_ONE) && (idx <= `GDP_IDX_GROUP_SIX);

  // one configuration byte per port position, reserved positions unmapped
  assign is_cfg_range = (idx >= `GDP_IDX_CFG_BASE) &&
    (idx < (`GDP_IDX_CFG_BASE + 7'd48));
  assign cfg_full = idx - `GDP_IDX_CFG_BASE;
  assign cfg_port = cfg_full[5:0];
  assign is_cfg = is_cfg_range && PIN_MASK[cfg_port];

  // ****************************************************************
  // per-port strobes
  // ****************************************************************

  reg [NUM_PORTS-1:0] data_we;
  reg [NUM_PORTS-1:0] data_rd;
  reg [NUM_PORTS-1:0] cfg_we;
  reg [NUM_PORTS-1:0] data_wbit;
  integer p;

  // a group access touches the pin-carrying ports among its eight positions, a config access one port
  always @* begin
    data_we = {NUM_PORTS{1'b0}};
    data_rd = {NUM_PORTS{1'b0}};
    cfg_we = {NUM_PORTS{1'b0}};
    data_wbit = {NUM_PORTS{1'b0}};
    for (p = 0; p < NUM_PORTS; p = p + 1) begin
      data_wbit[p] = wb_dat_i[p % 8];
      if (is_data && (grp == (p / 8))) begin
        data_we[p] = wr_req && lane0 && PIN_MASK[p];
        data_rd[p] = rd_req && PIN_MASK[p];
      end
      if (is_cfg && (cfg_port == p)) begin
        cfg_we[p] = wr_req && lane0;
      end
    end
  end

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************

  wire [NUM_PORTS-1:0] pin_lvl;

  gdp_sync2 #(
    .WIDTH(NUM_PORTS)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(pin_i),
    .sync_out(pin_lvl)
  );

  // ****************************************************************
  // port cells
  // ****************************************************************

  wire [8*NUM_PORTS-1:0] cfg_all;
  wire [NUM_PORTS-1:0] rd_view;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
      if (PIN_MASK[g]) begin : g_real
        gdp_pin_cell u_cell (
          .clk_sys(clk_sys),
          .rst(rst),
          .cfg_we(cfg_we[g]),
          .cfg_wdat(wb_dat_i[7:0]),
          .data_we(data_we[g]),
          .data_wbit(data_wbit[g]),
          .data_rd(data_rd[g]),
          .pin_lvl(pin_lvl[g]),
          .alt_out(alt_out[g]),
          .alt_dir_in(alt_dir_in[g]),
          .cfg(cfg_all[8*g+7:8*g]),
          .rd_view(rd_view[g]),
          .pin_o(pin_o[g]),
          .pin_oe_n(pin_oe_n[g]),
          .alt_in(alt_in[g])
        );
      end else begin : g_rsvd
        // reserved position: no pin, never driven, reads zero
        assign cfg_all[8*g+7:8*g] = 8'h00;
        assign rd_view[g] = 1'b0;
        assign pin_o[g] = 1'b0;
        assign pin_oe_n[g] = 1'b1;
        assign alt_in[g] = 1'b0;
      end
      // function select exported to the alternate function owners
      assign fn_sel[2*g+1:2*g] = cfg_all[8*g+`GDP_CFG_FSEL_HI:8*g+`GDP_CFG_FSEL_LO];
    end
  endgenerate

  // ****************************************************************
  // read data selection
  // ****************************************************************

  reg [7:0] rd_byte;
  integer b;

  // group byte, configuration byte, or zero for an unmapped index
  always @* begin
    rd_byte = 8'h00;
    if (is_data) begin
      for (b = 0; b < 8; b = b + 1) begin
        rd_byte[b] = rd_view[8 * grp + b];
      end
    end else if (is_cfg) begin
      rd_byte = cfg_all[8 * cfg_port +: 8];
    end
  end

  // ****************************************************************
  // wishbone answer
  // ****************************************************************

  // one cycle answer, ack dropped the cycle after it was given
  always @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd_req) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule

// [test/gdp_pad_model.sv]
// board side of the pins: resolves each pad wire from both drivers.
// assumes every pad has a pull-up when neither side drives it.
`timescale 1ns/1ps
module gdp_pad_model (
  input wire logic [47:0] pin_o,
  input wire logic [47:0] pin_oe_n,
  input wire logic [47:0] brd_val,
  input wire logic [47:0] brd_en,
  output logic [47:0] pad,
  output logic clash
);
  // device wins when driving, else board, else the pull-up
  assign pad = (~pin_oe_n & pin_o) | (pin_oe_n & brd_en & brd_val) | (pin_oe_n & ~brd_en);
  // both sides driving one wire is a board fault
  assign clash = |(~pin_oe_n & brd_en);
endmodule

// [test/gdp_gpio_bank_chk.sv]
// checker on the ports of the gpio bank.
// assumes a bind from the bench top; one clock domain.
`timescale 1ns/1ps
module gdp_gpio_bank_chk #(
  parameter ADDR_W = 9,
  parameter NUM_PORTS = 48
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_PORTS-1:0] pin_oe_n,
  input wire logic [2*NUM_PORTS-1:0] fn_sel
);
  // ****************************************************************
  // bus and pin properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic rd_req;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_byte_wide: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above byte lane");
  a_group4_resv_zero: assert property (rd_req && wb_adr_i == 9'h138 |=> wb_dat_o[7:4] == 4'h0)
    else $error("group four reserved bits not zero");
  a_group6_resv_zero: assert property (rd_req && wb_adr_i == 9'h140 |=> wb_dat_o[7:3] == 5'h0)
    else $error("group six reserved bits not zero");
  a_unmapped_read_zero: assert property (rd_req && (wb_adr_i == 9'h144 || wb_adr_i == 9'h070)
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_resv_never_driven: assert property (pin_oe_n[31:28] == 4'hf && pin_oe_n[47:43] == 5'h1f)
    else $error("reserved position driven");
  a_reset_gpio_input: assert property ($past(rst) |-> (&pin_oe_n) && fn_sel == '0)
    else $error("reset state not gpio input");
  a_oe_needs_write: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i) [*2] |=> $stable(pin_oe_n))
    else $error("drive enable changed without write");
endmodule

// [test/gdp_gpio_bank_tb_top.sv]
// self-checking bench for the gpio bank over classic wishbone.
// assumes the pad model resolves every pin wire.
`timescale 1ns/1ps
`include "gdp_defs.vh"
module gdp_gpio_bank_tb_top;
  // ****************************************************************
  // signals, design and board
  // ****************************************************************
  logic clk_sys, rst, cyc, stb, we, clash;
  logic [8:0] adr;
  logic [31:0] wdat, wb_dat_o;
  logic wb_ack_o;
  logic [47:0] pad, pin_o, pin_oe_n, brd_val, brd_en, alt_in, exp;
  logic [47:0] alt_out, alt_dir;
  logic [95:0] fn_sel;
  logic [7:0] q;
  int miscompares, compares;
  gdp_gpio_bank dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_i(pad), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .alt_out(alt_out), .alt_dir_in(alt_dir), .alt_in(alt_in), .fn_sel(fn_sel));
  gdp_pad_model pads (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .brd_val(brd_val),
    .brd_en(brd_en), .pad(pad), .clash(clash));
  // free running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // value compare
  task automatic chk(input string name, input logic [47:0] e, input logic [47:0] got);
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, got);
    end
  endtask
  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("ack wait", 48'h2, 48'(n));
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // one idle edge, one more so the pin registers show the write
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic rd(input string name, input logic [8:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(name, {40'h0, e}, {40'h0, q});
  endtask
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst <= 1'b1;
    {cyc, stb, we, adr, wdat} <= '0;
    brd_en <= {48{1'b1}};
    brd_val <= 48'h12_34_56_78_9a_bc;
    alt_out <= '0;
    alt_dir <= {48{1'b1}};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd("cfg0", 9'h000, 8'h01);
    rd("cfg42", 9'h0a8, 8'h01);
    exp = brd_val & `GDP_PIN_MASK;
    for (int g = 0; g < 6; g++) begin
      rd("group", {7'(`GDP_IDX_GROUP_ONE + g), 2'b00}, exp[8*g +: 8]);
    end
    wb(1'b1, 9'h138, 8'hff);
    rd("group4", 9'h138, 8'h06);
    wb(1'b1, 9'h000, 8'h03);
    rd("inv in", 9'h12c, 8'hbd);
    chk("alt in", 48'h1, {47'h0, alt_in[0]});
    brd_val[16] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    brd_en[16] <= 1'b0;
    wb(1'b1, 9'h040, 8'h00);
    chk("latched", 48'h0, {47'h0, pin_o[16] | pin_oe_n[16]});
    brd_en[15:8] <= 8'h00;
    for (int p = 8; p < 16; p++) wb(1'b1, 9'(4 * p), 8'h00);
    wb(1'b1, 9'h130, 8'ha5);
    chk("out", 48'ha5, {32'h0, pin_oe_n[15:8], pin_o[15:8]});
    rd("readback", 9'h130, 8'ha5);
    wb(1'b1, 9'h020, 8'h02);
    chk("inv out", 48'h0, {47'h0, pin_o[8]});
    wb(1'b1, 9'h024, 8'h80);
    chk("od low", 48'h0, {46'h0, pin_oe_n[9], pin_o[9]});
    wb(1'b1, 9'h130, 8'ha7);
    chk("od high", 48'h3, {46'h0, pin_oe_n[9], pad[9]});
    // port 10 handed to its first alternate function, which drives low
    alt_dir[10] <= 1'b0;
    alt_out[10] <= 1'b0;
    wb(1'b1, 9'h028, 8'h04);
    chk("alt drive", 48'h0, {46'h0, pin_oe_n[10], pin_o[10]});
    chk("fn sel", 48'h1, {46'h0, fn_sel[21:20]});
    wb(1'b1, 9'h070, 8'h00);
    rd("resv cfg", 9'h070, 8'h00);
    rd("unmapped", 9'h144, 8'h00);
    chk("clash", 48'h0, {47'h0, clash});
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end
endmodule
bind gdp_gpio_bank gdp_gpio_bank_chk #(.ADDR_W(ADDR_W), .NUM_PORTS(NUM_PORTS)) chk (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_oe_n(pin_oe_n),
  .fn_sel(fn_sel));
